// File: rtl/hhpsl_pkg.sv
// shared constants and types of the head host port and status lights block
package hhpsl_pkg;
  // ==========================================================
  // clock and timing
  localparam longint unsigned CLK_HZ = 125_000_000; // core clock rate
  localparam longint unsigned HEALTH_MHZ = 3800; // health blink, millihertz
  // cycles per half period of the health blink
  localparam longint unsigned HEALTH_HALF_CYC = CLK_HZ * 1000 / (2 * HEALTH_MHZ);
  localparam longint unsigned FLASH_SLOT_MS = 250; // one error-code slot
  localparam longint unsigned FLASH_SLOT_CYC = CLK_HZ / 1000 * FLASH_SLOT_MS;
  localparam int FLASH_SLOTS = 6; // flashes per code
  localparam int GAP_SLOTS = 2; // dark slots after the code
  // ==========================================================
  // axi4-lite register offsets (byte addresses)
  localparam int AXI_AW = 8; // bus address width used
  localparam logic [7:0] A_ADDR = 8'h00; // location latch
  localparam logic [7:0] A_DATA = 8'h04; // data at latched location
  localparam logic [7:0] A_IRQ_STAT = 8'h08; // sticky events, w1c
  localparam logic [7:0] A_IRQ_MASK = 8'h0c; // event enables
  localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer codes
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // host-visible locations behind the address latch
  localparam logic [7:0] H_ID = 8'h00; // identification
  localparam logic [7:0] H_STAT0 = 8'h01; // fifo flags
  localparam logic [7:0] H_STAT1 = 8'h02; // processor status
  localparam logic [7:0] H_FIFO = 8'h03; // message fifos
  localparam logic [7:0] H_EEPROM = 8'h04; // two-wire port bits
  localparam logic [7:0] H_PROCIF = 8'h05; // processor host interface
  // ==========================================================
  // processor local bus locations
  localparam logic [2:0] P_STAT0 = 3'h0; // status byte 0
  localparam logic [2:0] P_STAT1 = 3'h1; // status byte 1
  localparam logic [2:0] P_CTRL0 = 3'h2; // control byte 0
  localparam logic [2:0] P_CTRL1 = 3'h3; // control byte 1, code slots 0-3
  localparam logic [2:0] P_CTRL2 = 3'h4; // control byte 2, code slots 4-5
  localparam logic [2:0] P_FIFO = 3'h5; // message fifos
  localparam logic [2:0] P_HOSTIF = 3'h6; // host interface byte
  // control byte 0 fields
  localparam int C_RED = 0;
  localparam int C_YEL = 1;
  localparam int C_GRN = 2;
  localparam int C_AUTO = 3; // lights follow hardware sources
  localparam int C_FATAL = 4; // fatal error state
  localparam logic [7:0] CTRL_RST = 8'h00;
  // flash slot colour codes
  localparam logic [1:0] COL_RED = 2'h1;
  localparam logic [1:0] COL_YEL = 2'h2;
  localparam logic [1:0] COL_GRN = 2'h3;
  // ==========================================================
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int I_P2H_DATA = 0; // processor pushed a message byte
  localparam int I_H2P_SPACE = 1; // processor drained a host byte
  localparam int I_FATAL = 2; // fatal state entered
  localparam int I_PROCIF = 3; // processor wrote its host byte
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  // ==========================================================
  // light set
  typedef struct packed {
    logic red;
    logic yellow;
    logic green;
  } hhpsl_lights_s;
endpackage

// File: rtl/hhpsl_top.sv
// host port, message fifos, processor registers and status lights
`timescale 1ns/10ps
// Behaviour
// - host latches location, then accesses byte there
// - host reaches only listed resources
// - two message fifos, each direction
// - processor has two status, three control bytes
// - control register bits drive the lights
// - processor reset forces all lights on
// - green health light blinks near 3.8 Hz
// - yellow lit while stylus above null
// - red lit while acquisition trigger active
// - fatal state ignores host writes to the data location
// - each flash slot shows one colour
module hhpsl_top #(
  parameter int DEPTH = 8, // fifo depth in bytes
  parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary identification value
  parameter int HEALTH_HALF = int'(hhpsl_pkg::HEALTH_HALF_CYC), // blink half period
  parameter int SLOT_CYC = int'(hhpsl_pkg::FLASH_SLOT_CYC) // flash slot length
) (
  input wire logic CLOCK, // core clock
  input wire logic RST_B, // async reset, low active
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // byte enables
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  output logic IRQ, // level interrupt
  input wire logic PROC_RST_B, // processor held in reset, low active
  input wire logic PROC_SEL, // processor bus access strobe
  input wire logic PROC_WR, // processor access is a write
  input wire logic [2:0] PROC_ADDR, // processor location
  input wire logic [7:0] PROC_WDATA, // processor write byte
  output logic [7:0] PROC_RDATA, // processor read byte, next cycle
  input wire logic STYLUS_ABOVE_NULL, // stylus above null point
  input wire logic TRIGGER_B, // acquisition trigger, low active
  output logic EE_SCL, // calibration memory clock
  output logic EE_SDA_O, // data out, always low
  output logic EE_SDA_OE, // data enable, pulls line low
  input wire logic EE_SDA_I, // data line level
  output logic RED_ACQUIRE_LIGHT, // red light
  output logic YELLOW_ABOVE_NULL_LIGHT, // yellow light
  output logic GREEN_HEALTH_LIGHT // green light
);
  // ==========================================================
  // state
  localparam int PW = $clog2(DEPTH); // pointer width
  typedef logic [PW-1:0] hhpsl_ptr_t;
  typedef struct packed {
    logic [7:0] awaddr; // held write address
    logic aw_ok; // write address held
    logic [7:0] wdata; // held write byte
    logic [3:0] wstrb; // held byte enables
    logic w_ok; // write data held
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] loc; // latched host location
    logic [hhpsl_pkg::IRQ_W-1:0] irq_stat;
    logic [hhpsl_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic scl; // two-wire clock bit
    logic sda_low; // two-wire data pulled low
    logic [7:0] hif_h2p; // host byte to processor
    logic [7:0] hif_p2h; // processor byte to host
    logic [2:0][7:0] ctrl; // processor control bytes
    logic [7:0] prdata;
    logic [DEPTH-1:0][7:0] h2p_mem;
    hhpsl_ptr_t h2p_wp;
    hhpsl_ptr_t h2p_rp;
    logic [PW:0] h2p_cnt;
    logic [DEPTH-1:0][7:0] p2h_mem;
    hhpsl_ptr_t p2h_wp;
    hhpsl_ptr_t p2h_rp;
    logic [PW:0] p2h_cnt;
    logic [31:0] hcnt; // health blink timer
    logic hblink; // health blink phase
    logic [31:0] fcnt; // flash slot timer
    logic [2:0] fslot; // flash slot index
    hhpsl_pkg::hhpsl_lights_s lights;
  } hhpsl_state_s;

  hhpsl_state_s s_q; // registered state
  hhpsl_state_s s_d; // next state

  // pointer step with wrap at the fifo depth
  function automatic hhpsl_ptr_t ptr_inc(input hhpsl_ptr_t p);
    ptr_inc = (p == hhpsl_ptr_t'(DEPTH - 1)) ? '0 : p + hhpsl_ptr_t'(1);
  endfunction

  // colour code of one flash slot to a light set
  function automatic hhpsl_pkg::hhpsl_lights_s colour(input logic [1:0] c);
    colour.red = (c == hhpsl_pkg::COL_RED);
    colour.yellow = (c == hhpsl_pkg::COL_YEL);
    colour.green = (c == hhpsl_pkg::COL_GRN);
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic wr_go; // write performed this cycle
    logic rd_go; // read taken this cycle
    logic fatal; // fatal state active
    logic h2p_push, h2p_pop, p2h_push, p2h_pop;
    logic [7:0] hrd; // byte read at the latched location
    logic [11:0] code; // six two-bit colour slots
    logic [1:0] slot_col;
    s_d = s_q;
    wr_go = 1'b0;
    rd_go = 1'b0;
    h2p_push = 1'b0;
    h2p_pop = 1'b0;
    p2h_push = 1'b0;
    p2h_pop = 1'b0;
    hrd = 8'h00;
    slot_col = 2'h0;
    fatal = s_q.ctrl[0][hhpsl_pkg::C_FATAL];
    code = {s_q.ctrl[2][3:0], s_q.ctrl[1]};
    // write channel capture, in either order
    if (S_AXI_AWVALID && s_q.awready) begin
      s_d.awaddr = S_AXI_AWADDR;
      s_d.aw_ok = 1'b1;
    end
    if (S_AXI_WVALID && s_q.wready) begin
      s_d.wdata = S_AXI_WDATA[7:0];
      s_d.wstrb = S_AXI_WSTRB;
      s_d.w_ok = 1'b1;
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    // both halves held: perform and answer
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
      wr_go = 1'b1;
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = hhpsl_pkg::RESP_OKAY;
    end
    if (wr_go && s_q.wstrb[0]) begin
      case (s_q.awaddr)
        hhpsl_pkg::A_ADDR: s_d.loc = s_q.wdata; // latch location
        hhpsl_pkg::A_DATA: begin
          // fatal state drops host writes
          if (!fatal) begin
            case (s_q.loc) // byte goes to the latched location
              hhpsl_pkg::H_FIFO: h2p_push = (s_q.h2p_cnt != (PW+1)'(DEPTH));
              hhpsl_pkg::H_EEPROM: begin
                // host drives both two-wire lines bit by bit
                s_d.scl = s_q.wdata[0];
                s_d.sda_low = !s_q.wdata[1];
              end
              hhpsl_pkg::H_PROCIF: s_d.hif_h2p = s_q.wdata;
              default: ; // other locations are read-only or absent
            endcase
          end
        end
        hhpsl_pkg::A_IRQ_MASK: s_d.irq_mask = s_q.wdata[hhpsl_pkg::IRQ_W-1:0];
        hhpsl_pkg::A_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~s_q.wdata[3:0];
        default: ;
      endcase
    end
    if (wr_go && !(s_q.awaddr inside {hhpsl_pkg::A_ADDR, hhpsl_pkg::A_DATA,
        hhpsl_pkg::A_IRQ_STAT, hhpsl_pkg::A_IRQ_MASK})) begin
      s_d.bresp = hhpsl_pkg::RESP_SLVERR; // unmapped address
    end
    s_d.awready = !s_d.aw_ok && !s_d.bvalid;
    s_d.wready = !s_d.w_ok && !s_d.bvalid;
    // read channel
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    // host view of the latched location; only the listed resources
    case (s_q.loc)
      hhpsl_pkg::H_ID: hrd = ID_CODE;
      // fifo empty and full flags for both directions
      hhpsl_pkg::H_STAT0: hrd = {4'h0, s_q.p2h_cnt == (PW+1)'(DEPTH),
          s_q.p2h_cnt == '0, s_q.h2p_cnt == (PW+1)'(DEPTH), s_q.h2p_cnt == '0};
      hhpsl_pkg::H_STAT1: hrd = {5'h00, !PROC_RST_B, fatal, s_q.irq};
      hhpsl_pkg::H_FIFO: hrd = (s_q.p2h_cnt != '0) ? s_q.p2h_mem[s_q.p2h_rp] : 8'h00;
      hhpsl_pkg::H_EEPROM: hrd = {5'h00, EE_SDA_I, !s_q.sda_low, s_q.scl};
      hhpsl_pkg::H_PROCIF: hrd = s_q.hif_p2h;
      default: hrd = 8'h00;
    endcase
    if (S_AXI_ARVALID && s_q.arready) begin
      rd_go = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp = hhpsl_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        hhpsl_pkg::A_ADDR: s_d.rdata = {24'h000000, s_q.loc};
        hhpsl_pkg::A_DATA: begin
          s_d.rdata = {24'h000000, hrd}; // read at the latched location
          p2h_pop = (s_q.loc == hhpsl_pkg::H_FIFO) && (s_q.p2h_cnt != '0);
        end
        hhpsl_pkg::A_IRQ_STAT: s_d.rdata = {28'h0000000, s_q.irq_stat};
        hhpsl_pkg::A_IRQ_MASK: s_d.rdata = {28'h0000000, s_q.irq_mask};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = hhpsl_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid && !rd_go;
    // processor local bus: two status and three control bytes
    if (PROC_SEL && !PROC_WR) begin
      case (PROC_ADDR)
        hhpsl_pkg::P_STAT0: s_d.prdata = {4'h0, s_q.h2p_cnt == (PW+1)'(DEPTH),
            s_q.h2p_cnt == '0, s_q.p2h_cnt == (PW+1)'(DEPTH), s_q.p2h_cnt == '0};
        hhpsl_pkg::P_STAT1: s_d.prdata = {6'h00, !TRIGGER_B, STYLUS_ABOVE_NULL};
        hhpsl_pkg::P_CTRL0: s_d.prdata = s_q.ctrl[0];
        hhpsl_pkg::P_CTRL1: s_d.prdata = s_q.ctrl[1];
        hhpsl_pkg::P_CTRL2: s_d.prdata = s_q.ctrl[2];
        hhpsl_pkg::P_FIFO: begin
          s_d.prdata = (s_q.h2p_cnt != '0) ? s_q.h2p_mem[s_q.h2p_rp] : 8'h00;
          h2p_pop = (s_q.h2p_cnt != '0);
        end
        hhpsl_pkg::P_HOSTIF: s_d.prdata = s_q.hif_h2p;
        default: s_d.prdata = 8'h00;
      endcase
    end
    if (PROC_SEL && PROC_WR) begin
      case (PROC_ADDR)
        hhpsl_pkg::P_CTRL0: s_d.ctrl[0] = PROC_WDATA;
        hhpsl_pkg::P_CTRL1: s_d.ctrl[1] = PROC_WDATA;
        hhpsl_pkg::P_CTRL2: s_d.ctrl[2] = PROC_WDATA;
        hhpsl_pkg::P_FIFO: p2h_push = (s_q.p2h_cnt != (PW+1)'(DEPTH));
        hhpsl_pkg::P_HOSTIF: s_d.hif_p2h = PROC_WDATA;
        default: ; // status bytes are read-only
      endcase
    end
    // fifo bookkeeping; full writes and empty reads are dropped
    if (h2p_push) begin
      s_d.h2p_mem[s_q.h2p_wp] = s_q.wdata;
      s_d.h2p_wp = ptr_inc(s_q.h2p_wp);
    end
    if (h2p_pop) begin
      s_d.h2p_rp = ptr_inc(s_q.h2p_rp);
    end
    s_d.h2p_cnt = s_q.h2p_cnt + (PW+1)'(h2p_push) - (PW+1)'(h2p_pop);
    if (p2h_push) begin
      s_d.p2h_mem[s_q.p2h_wp] = PROC_WDATA;
      s_d.p2h_wp = ptr_inc(s_q.p2h_wp);
    end
    if (p2h_pop) begin
      s_d.p2h_rp = ptr_inc(s_q.p2h_rp);
    end
    s_d.p2h_cnt = s_q.p2h_cnt + (PW+1)'(p2h_push) - (PW+1)'(p2h_pop);
    // processor reset clears control bytes
    if (!PROC_RST_B) begin
      s_d.ctrl = {3{hhpsl_pkg::CTRL_RST}};
    end
    // sticky events: a set in the clearing cycle wins
    s_d.irq_stat[hhpsl_pkg::I_P2H_DATA] = s_d.irq_stat[hhpsl_pkg::I_P2H_DATA] | p2h_push;
    s_d.irq_stat[hhpsl_pkg::I_H2P_SPACE] = s_d.irq_stat[hhpsl_pkg::I_H2P_SPACE] | h2p_pop;
    s_d.irq_stat[hhpsl_pkg::I_FATAL] = s_d.irq_stat[hhpsl_pkg::I_FATAL]
        | (s_d.ctrl[0][hhpsl_pkg::C_FATAL] && !fatal);
    s_d.irq_stat[hhpsl_pkg::I_PROCIF] = s_d.irq_stat[hhpsl_pkg::I_PROCIF]
        | (PROC_SEL && PROC_WR && PROC_ADDR == hhpsl_pkg::P_HOSTIF);
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    // health blink timer, half period per toggle
    if (s_q.hcnt >= 32'(HEALTH_HALF - 1)) begin
      s_d.hcnt = 32'h00000000;
      s_d.hblink = !s_q.hblink;
    end else begin
      s_d.hcnt = s_q.hcnt + 32'h00000001;
    end
    // flash slot timer, runs only in fatal state
    if (!fatal) begin
      s_d.fcnt = 32'h00000000;
      s_d.fslot = 3'h0;
    end else if (s_q.fcnt >= 32'(SLOT_CYC - 1)) begin
      s_d.fcnt = 32'h00000000;
      s_d.fslot = (s_q.fslot == 3'(hhpsl_pkg::FLASH_SLOTS + hhpsl_pkg::GAP_SLOTS - 1))
          ? 3'h0 : s_q.fslot + 3'h1; // repeats until reset
    end else begin
      s_d.fcnt = s_q.fcnt + 32'h00000001;
    end
    // light selection
    if (!PROC_RST_B) begin
      s_d.lights = '{red: 1'b1, yellow: 1'b1, green: 1'b1};
    end else if (fatal) begin
      // first half of six slots lit, gap dark
      if (s_q.fslot < 3'(hhpsl_pkg::FLASH_SLOTS) && s_q.fcnt < 32'(SLOT_CYC / 2)) begin
        slot_col = code[2*s_q.fslot +: 2];
        s_d.lights = colour(slot_col); // one colour per slot
      end else begin
        s_d.lights = '0;
      end
    end else if (s_q.ctrl[0][hhpsl_pkg::C_AUTO]) begin
      s_d.lights.green = s_q.hblink;
      s_d.lights.yellow = STYLUS_ABOVE_NULL;
      s_d.lights.red = !TRIGGER_B;
    end else begin
      // lights straight from control bits
      s_d.lights.red = s_q.ctrl[0][hhpsl_pkg::C_RED];
      s_d.lights.yellow = s_q.ctrl[0][hhpsl_pkg::C_YEL];
      s_d.lights.green = s_q.ctrl[0][hhpsl_pkg::C_GRN];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.irq_stat <= hhpsl_pkg::IRQ_RST;
      s_q.ctrl <= {3{hhpsl_pkg::CTRL_RST}};
      s_q.scl <= 1'b1; // idle two-wire bus high
      s_q.lights <= '{red: 1'b1, yellow: 1'b1, green: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all but EE_SDA_O from the state register
  assign S_AXI_AWREADY = s_q.awready;
  assign S_AXI_WREADY = s_q.wready;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_ARREADY = s_q.arready;
  assign S_AXI_RDATA = s_q.rdata;
  assign S_AXI_RRESP = s_q.rresp;
  assign S_AXI_RVALID = s_q.rvalid;
  assign IRQ = s_q.irq;
  assign PROC_RDATA = s_q.prdata;
  assign EE_SCL = s_q.scl;
  assign EE_SDA_O = 1'b0; // open drain: only ever pulls low
  assign EE_SDA_OE = s_q.sda_low;
  assign RED_ACQUIRE_LIGHT = s_q.lights.red;
  assign YELLOW_ABOVE_NULL_LIGHT = s_q.lights.yellow;
  assign GREEN_HEALTH_LIGHT = s_q.lights.green;
endmodule

// File: verification/hhpsl_wire_partner.sv
// two-wire data line model with pull-up
`timescale 1ns/10ps
module hhpsl_wire_partner (
  input wire logic sda_oe, // block pulls low
  input wire logic ack, // memory pulls low
  output logic sda // line level
);
  // open drain: released line rests high
  assign sda = !(sda_oe || ack);
endmodule

// File: verification/hhpsl_properties.sv
// port checks of the host port and status lights block
`timescale 1ns/10ps
module hhpsl_properties (
  input wire logic CLOCK, // core clock
  input wire logic RST_B, // async reset, low active
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  input wire logic S_AXI_AWREADY, // write address ready
  input wire logic S_AXI_WVALID, // write data valid
  input wire logic S_AXI_WREADY, // write data ready
  input wire logic [1:0] S_AXI_BRESP, // write response
  input wire logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  input wire logic S_AXI_ARREADY, // read address ready
  input wire logic [31:0] S_AXI_RDATA, // read data
  input wire logic [1:0] S_AXI_RRESP, // read response
  input wire logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY, // read data ready
  input wire logic PROC_RST_B, // processor reset, low active
  input wire logic EE_SDA_O, // two-wire data out
  input wire logic RED_ACQUIRE_LIGHT, // red light
  input wire logic YELLOW_ABOVE_NULL_LIGHT, // yellow light
  input wire logic GREEN_HEALTH_LIGHT // green light
);
  // ==========================================================
  // one clock domain
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // processor reset forces lights
  lights_reset_a: assert property (!PROC_RST_B |=> RED_ACQUIRE_LIGHT &&
    YELLOW_ABOVE_NULL_LIGHT && GREEN_HEALTH_LIGHT) else $error("lights not forced on");
  // data output only pulls low
  wire_low_a: assert property (EE_SDA_O == 1'b0) else $error("data output not low");
  // read answer one cycle on
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID &&
    S_AXI_RRESP == ($past(S_AXI_ARADDR) > 8'h0c ? 2'h2 : 2'h0)) else $error("read answer");
  read_refuse_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR > 8'h0c |=> S_AXI_RDATA == 32'h0) else $error("refused read data");
  // write answer two cycles on
  write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##2 S_AXI_BVALID && S_AXI_BRESP == ($past(S_AXI_AWADDR, 2) > 8'h0c ?
    2'h2 : 2'h0)) else $error("write answer");
  // answers stand until taken
  read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
    $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("read dropped");
  write_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID &&
    $stable(S_AXI_BRESP)) else $error("write dropped");
  // one write at a time
  bus_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
endmodule
bind hhpsl_top hhpsl_properties i_hhpsl_properties (.*);

// File: verification/hhpsl_top_tb.sv
// bench of the host port and status lights block
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module hhpsl_top_tb;
  localparam int SLOT = 8; // short slot
  localparam int HALF = 10; // short blink
  logic CLOCK, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  logic PROC_RST_B, PROC_SEL, PROC_WR, STYLUS_ABOVE_NULL, TRIGGER_B, ee_ack;
  logic EE_SCL, EE_SDA_O, EE_SDA_OE, EE_SDA_I;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, PROC_WDATA, PROC_RDATA;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [2:0] PROC_ADDR;
  hhpsl_pkg::hhpsl_lights_s lt; // red, yellow, green
  int miscompares, n_checks;
  hhpsl_top #(.DEPTH(8), .ID_CODE(8'h3c), .HEALTH_HALF(HALF), .SLOT_CYC(SLOT)) i_hhpsl_top (
    .*,
    .RED_ACQUIRE_LIGHT(lt.red),
    .YELLOW_ABOVE_NULL_LIGHT(lt.yellow),
    .GREEN_HEALTH_LIGHT(lt.green)
  );
  hhpsl_wire_partner i_hhpsl_wire_partner (.sda_oe(EE_SDA_OE), .ack(ee_ack), .sda(EE_SDA_I));
  // ==========================================================
  // bus tasks
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (n == 50) miscompares++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (n == 50) miscompares++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    `CHK(r, hhpsl_pkg::RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    `CHK(r, hhpsl_pkg::RESP_OKAY)
    `CHK(d, e)
  endtask
  // read a host location
  task automatic hloc(input logic [7:0] loc, input logic [7:0] e);
    wr(hhpsl_pkg::A_ADDR, loc);
    rd(hhpsl_pkg::A_DATA, {24'h0, e});
  endtask
  // one-strobe processor access
  task automatic pa(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    PROC_SEL <= 1'b1;
    PROC_WR <= w;
    PROC_ADDR <= a;
    PROC_WDATA <= d;
    @(posedge CLOCK);
    PROC_SEL <= 1'b0;
  endtask
  task automatic prd(input logic [2:0] a, input logic [7:0] e);
    pa(1'b0, a, 8'h00);
    @(negedge CLOCK);
    `CHK(PROC_RDATA, e)
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_map();
    logic [31:0] d;
    logic [1:0] r;
    @(negedge CLOCK);
    `CHK(lt, 3'b111)
    hloc(hhpsl_pkg::H_STAT1, 8'h04);
    rd(hhpsl_pkg::A_IRQ_STAT, 32'h0);
    @(posedge CLOCK);
    PROC_RST_B <= 1'b1;
    hloc(hhpsl_pkg::H_ID, 8'h3c);
    hloc(8'h07, 8'h00);
    rd(hhpsl_pkg::A_ADDR, 32'h07);
    axr(8'h10, d, r);
    `CHK({r, d}, {hhpsl_pkg::RESP_SLVERR, 32'h0})
    axw(8'h14, 8'hff, r);
    `CHK(r, hhpsl_pkg::RESP_SLVERR)
  endtask
  task automatic t_fifo();
    wr(hhpsl_pkg::A_IRQ_MASK, 8'h0f);
    hloc(hhpsl_pkg::H_STAT0, 8'h05);
    wr(hhpsl_pkg::A_ADDR, hhpsl_pkg::H_FIFO);
    // ninth byte is dropped
    for (int i = 0; i <= 8; i++) wr(hhpsl_pkg::A_DATA, 8'h10 + 8'(i));
    hloc(hhpsl_pkg::H_STAT0, 8'h06);
    prd(hhpsl_pkg::P_STAT0, 8'h09);
    for (int i = 0; i < 8; i++) prd(hhpsl_pkg::P_FIFO, 8'h10 + 8'(i));
    prd(hhpsl_pkg::P_STAT0, 8'h05);
    rd(hhpsl_pkg::A_IRQ_STAT, 32'h2);
    `CHK(IRQ, 1'b1)
    wr(hhpsl_pkg::A_IRQ_STAT, 8'h02);
    `CHK(IRQ, 1'b0)
    pa(1'b1, hhpsl_pkg::P_FIFO, 8'ha5);
    pa(1'b1, hhpsl_pkg::P_FIFO, 8'h5a);
    wr(hhpsl_pkg::A_IRQ_MASK, 8'h0e);
    rd(hhpsl_pkg::A_IRQ_STAT, 32'h1);
    `CHK(IRQ, 1'b0)
    hloc(hhpsl_pkg::H_FIFO, 8'ha5);
    rd(hhpsl_pkg::A_DATA, 32'h5a);
    rd(hhpsl_pkg::A_DATA, 32'h0);
    pa(1'b1, hhpsl_pkg::P_HOSTIF, 8'hc3);
    hloc(hhpsl_pkg::H_PROCIF, 8'hc3);
    `CHK(IRQ, 1'b1)
    wr(hhpsl_pkg::A_IRQ_STAT, 8'h0f);
    {STYLUS_ABOVE_NULL, TRIGGER_B} <= 2'b10;
    prd(hhpsl_pkg::P_STAT1, 8'h03);
  endtask
  task automatic t_lights();
    logic g;
    int n;
    for (int i = 0; i < 8; i++) begin
      pa(1'b1, hhpsl_pkg::P_CTRL0, 8'(i));
      repeat (2) @(negedge CLOCK);
      `CHK(lt, {i[0], i[1], i[2]})
    end
    pa(1'b1, hhpsl_pkg::P_CTRL0, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLOCK);
      STYLUS_ABOVE_NULL <= i[0];
      TRIGGER_B <= i[1];
      repeat (3) @(negedge CLOCK);
      `CHK({lt.red, lt.yellow}, {~i[1], i[0]})
    end
    // time one blink level
    @(negedge CLOCK);
    g = lt.green;
    for (n = 0; n < 40 && lt.green === g; n++) @(negedge CLOCK);
    g = lt.green;
    for (n = 1; n < 40; n++) begin
      @(negedge CLOCK);
      if (lt.green !== g) break;
    end
    `CHK(n, HALF)
  endtask
  task automatic t_wire();
    wr(hhpsl_pkg::A_ADDR, hhpsl_pkg::H_EEPROM);
    wr(hhpsl_pkg::A_DATA, 8'h01);
    `CHK({EE_SCL, EE_SDA_OE}, 2'b11)
    rd(hhpsl_pkg::A_DATA, 32'h1);
    wr(hhpsl_pkg::A_DATA, 8'h02);
    rd(hhpsl_pkg::A_DATA, 32'h6);
    ee_ack <= 1'b1;
    rd(hhpsl_pkg::A_DATA, 32'h2);
    ee_ack <= 1'b0;
  endtask
  task automatic t_fatal();
    logic [2:0] col [6] = '{3'b100, 3'b010, 3'b001, 3'b100, 3'b010, 3'b001};
    int run;
    pa(1'b1, hhpsl_pkg::P_CTRL1, 8'h79);
    pa(1'b1, hhpsl_pkg::P_CTRL2, 8'h0e);
    pa(1'b1, hhpsl_pkg::P_CTRL0, 8'h10);
    wr(hhpsl_pkg::A_ADDR, hhpsl_pkg::H_FIFO);
    wr(hhpsl_pkg::A_DATA, 8'h77);
    hloc(hhpsl_pkg::H_STAT0, 8'h05);
    hloc(hhpsl_pkg::H_STAT1, 8'h03);
    // sync to the start of slot 0
    run = 0;
    for (int n = 0; n < 200; n++) begin
      @(negedge CLOCK);
      if (lt != 3'b000 && run >= 12) break;
      run = (lt == 3'b000) ? run + 1 : 0;
    end
    for (int i = 0; i < 6; i++) begin
      `CHK(lt, col[i])
      repeat (SLOT / 2) @(negedge CLOCK);
      `CHK(lt, 3'b000)
      repeat (SLOT / 2) @(negedge CLOCK);
    end
    `CHK(lt, 3'b000)
    repeat (2 * SLOT) @(negedge CLOCK);
    `CHK(lt, col[0])
    @(posedge CLOCK);
    PROC_RST_B <= 1'b0;
    repeat (2) @(negedge CLOCK);
    `CHK(lt, 3'b111)
    @(posedge CLOCK);
    PROC_RST_B <= 1'b1;
    repeat (3) @(negedge CLOCK);
    `CHK(lt, 3'b000)
  endtask
  // ==========================================================
  // clock, watchdog, main
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {PROC_RST_B, PROC_SEL, PROC_WR, STYLUS_ABOVE_NULL, ee_ack} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, PROC_ADDR, PROC_WDATA} = '0;
    TRIGGER_B = 1'b1;
    S_AXI_WSTRB = 4'h1;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge CLOCK);
    RST_B <= 1'b1;
    t_map();
    t_fifo();
    t_lights();
    t_wire();
    t_fatal();
    give_verdict();
  end
endmodule
